// file: hw/phymc_top.sv
// PHY management control block: host registers and management frame engine.
`timescale 1ns/100ps
module phymc_top
  import phymc_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = 5'h00
)
(
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Host register access, byte wide.
  input wire logic [15:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  // Levels from registers kept elsewhere in the device.
  input wire logic phy_write_lock,
  input wire logic system_clock_select,
  input wire logic global_mode_wake,
  // Live PHY status.
  input wire logic cable_unplugged_flag,
  input wire logic actual_duplex_flag,
  input wire logic actual_speed_flag,
  input wire logic link_up_flag,
  input wire logic phy_active_flag,
  input wire logic new_page_received_flag,
  input wire logic low_power_idle_flag,
  input wire logic calibration_flag,
  // Management serial port to the PHY.
  output logic mgmt_clock,
  output logic mgmt_data_out,
  output logic mgmt_data_oe,
  input wire logic mgmt_data_in,
  // PHY and clock control.
  output logic [2:0] phy_mode,
  output logic phy_power_down_bit,
  output logic phy_hw_reset,
  output logic system_clock_slow,
  output logic wake_on_lan_enable
);

  // ***************************************************
  // Declarations
  // ***************************************************
  logic [15:0] mru_reg;
  logic [15:0] mru_next;
  logic [7:0] link_status_reg;
  logic [7:0] act_status_reg;
  logic [4:0] ind_addr_reg;
  logic [15:0] wdata_reg;
  logic [15:0] rdata_reg;
  logic [7:0] cmd_reg;
  logic [7:0] divider_reg;
  logic [2:0] mode_reg;
  logic wake_reg;
  logic phy_power_down_bit_reg;
  logic rst_reg;
  logic rst_seen_idle_reg;
  logic [7:0] bus_rdata_reg;
  logic slow_reg;
  logic wol_reg;
  phymc_state_t state_reg;
  logic [6:0] half_reg;
  logic [6:0] div_cnt_reg;
  logic [6:0] bit_cnt_reg;
  logic [63:0] shift_reg;
  logic [15:0] capture_reg;
  logic mdc_reg;
  logic mdo_reg;
  logic mdo_oe_reg;
  logic tick;
  logic start;
  logic wr_ctrl_ok;
  logic [6:0] half_sel;
  logic [63:0] frame;

  if (PHY_ADDR > ADDR_FIELD_MASK)
  begin : g_check
    $error("PHY_ADDR does not fit the five-bit address field.");
  end

  assign wr_ctrl_ok = bus_wr && phy_write_lock;
  assign tick = (state_reg == PHYMC_XFER) && (div_cnt_reg == half_reg - 7'h01);
  assign start = bus_wr && (bus_addr == ADDR_ACCESS_CMD) &&
                 (state_reg == PHYMC_IDLE) &&
                 ((bus_wdata == CMD_WRITE) || (bus_wdata == CMD_READ));

  // Divider choice; anything but the two low codes takes the slowest rate.
  always_comb
  begin
    case (divider_reg)
      DIV_SEL_32: half_sel = HALF_32;
      DIV_SEL_64: half_sel = HALF_64;
      default: half_sel = HALF_128;
    endcase
  end

  // Frame image: preamble, start, opcode, addresses, turnaround, data.
  always_comb
  begin
    if (bus_wdata == CMD_WRITE)
      frame = {FRAME_PREAMBLE, FRAME_START, FRAME_OP_WRITE, PHY_ADDR,
               ind_addr_reg, FRAME_TURN_WRITE, wdata_reg};
    else
      frame = {FRAME_PREAMBLE, FRAME_START, FRAME_OP_READ, PHY_ADDR,
               ind_addr_reg, FRAME_TURN_READ, 16'hFFFF};
  end

  // Clamp the receive unit as each byte lands, so no read after a write shows overflow.
  always_comb
  begin
    mru_next = mru_reg;
    if (bus_addr == ADDR_MRU_HI)
      mru_next = {bus_wdata, mru_reg[7:0]};
    else
      mru_next = {mru_reg[15:8], bus_wdata};
    if (mru_next > MRU_LIMIT)
      mru_next = MRU_LIMIT;
  end

  // ***************************************************
  // Host-written registers
  // ***************************************************
  // Receive unit; the reset value is left unclamped on purpose.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      mru_reg <= MRU_RESET;
    else if (bus_wr && (bus_addr == ADDR_MRU_HI || bus_addr == ADDR_MRU_LO))
      mru_reg <= mru_next;
  end

  // Indirect address, write data and clock divider.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      ind_addr_reg <= 5'h00;
      wdata_reg <= 16'h0000;
      divider_reg <= DIVIDER_RESET;
    end
    else if (bus_wr)
    begin
      if (bus_addr == ADDR_IND_ADDRESS)
        ind_addr_reg <= bus_wdata[4:0];
      if (bus_addr == ADDR_WDATA_LO)
        wdata_reg[7:0] <= bus_wdata;
      if (bus_addr == ADDR_WDATA_HI)
        wdata_reg[15:8] <= bus_wdata;
      if (bus_addr == ADDR_CLK_DIVIDER)
        divider_reg <= bus_wdata;
    end
  end

  // Control registers take writes only while the PHY lock is open.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      mode_reg <= 3'h0;
      wake_reg <= 1'b0;
      phy_power_down_bit_reg <= 1'b0;
    end
    else if (wr_ctrl_ok)
    begin
      if (bus_addr == ADDR_MODE_CTRL)
        mode_reg <= bus_wdata[2:0];
      if (bus_addr == ADDR_POWER_CTRL)
      begin
        wake_reg <= bus_wdata[CR1_WAKE_BIT];
        phy_power_down_bit_reg <= bus_wdata[CR1_PHY_POWER_DOWN_BIT_BIT];
      end
    end
  end

  // PHY reset bit: starts set; clears once activity returns after dropping.
  // A new set request wins over the clear in the same cycle.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      rst_reg <= 1'b1;
      rst_seen_idle_reg <= 1'b0;
    end
    else if (wr_ctrl_ok && bus_addr == ADDR_POWER_CTRL &&
             bus_wdata[CR1_RESET_BIT])
    begin
      rst_reg <= 1'b1;
      rst_seen_idle_reg <= 1'b0;
    end
    else if (rst_reg)
    begin
      if (!phy_active_flag)
        rst_seen_idle_reg <= 1'b1;
      else if (rst_seen_idle_reg)
        rst_reg <= 1'b0;
    end
  end

  // ***************************************************
  // Status registers and control outputs
  // ***************************************************
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      link_status_reg <= LINK_RESET;
      act_status_reg <= ACT_RESET;
    end
    else
    begin
      link_status_reg <= {cable_unplugged_flag, 1'b0, mode_reg,
                          actual_duplex_flag, actual_speed_flag,
                          link_up_flag};
      act_status_reg <= {phy_active_flag, 4'h0, new_page_received_flag,
                         low_power_idle_flag, calibration_flag};
    end
  end

  // Slow clock whenever power-down, clock-select or PHY reset asks for it.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      slow_reg <= 1'b1;
      wol_reg <= 1'b0;
    end
    else
    begin
      slow_reg <= phy_power_down_bit_reg || system_clock_select || rst_reg;
      wol_reg <= wake_reg && global_mode_wake;
    end
  end

  // Read data path; write-only registers read back as zero.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      bus_rdata_reg <= 8'h00;
    else if (bus_rd)
    begin
      case (bus_addr)
        ADDR_MRU_HI: bus_rdata_reg <= mru_reg[15:8];
        ADDR_MRU_LO: bus_rdata_reg <= mru_reg[7:0];
        ADDR_LINK_STATUS: bus_rdata_reg <= link_status_reg;
        ADDR_ACT_STATUS: bus_rdata_reg <= act_status_reg;
        ADDR_IND_ADDRESS: bus_rdata_reg <= {3'h0, ind_addr_reg};
        ADDR_WDATA_LO: bus_rdata_reg <= wdata_reg[7:0];
        ADDR_WDATA_HI: bus_rdata_reg <= wdata_reg[15:8];
        ADDR_RDATA_LO: bus_rdata_reg <= rdata_reg[7:0];
        ADDR_RDATA_HI: bus_rdata_reg <= rdata_reg[15:8];
        ADDR_ACCESS_CMD: bus_rdata_reg <= cmd_reg;
        ADDR_CLK_DIVIDER: bus_rdata_reg <= divider_reg;
        ADDR_POWER_CTRL: bus_rdata_reg <= POWER_RSVD_ONES |
                          {2'h0, phy_power_down_bit_reg, 4'h0, rst_reg};
        default: bus_rdata_reg <= 8'h00;
      endcase
    end
  end

  // ***************************************************
  // Management frame engine
  // ***************************************************
  // The divider is latched at start so a mid-frame write cannot glitch MDC.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      state_reg <= PHYMC_IDLE;
      cmd_reg <= CMD_NONE;
      half_reg <= HALF_64;
      div_cnt_reg <= 7'h00;
    end
    else if (start)
    begin
      state_reg <= PHYMC_XFER;
      cmd_reg <= bus_wdata;
      half_reg <= half_sel;
      div_cnt_reg <= 7'h00;
    end
    else
    begin
      case (state_reg)
        PHYMC_XFER:
        begin
          div_cnt_reg <= tick ? 7'h00 : div_cnt_reg + 7'h01;
          if (tick && mdc_reg && bit_cnt_reg == FRAME_BITS)
          begin
            state_reg <= PHYMC_IDLE;
            cmd_reg <= CMD_NONE;
          end
        end
        default: div_cnt_reg <= 7'h00;
      endcase
    end
  end

  // Bits leave on falling MDC and are sampled on rising MDC.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      mdc_reg <= 1'b0;
      mdo_reg <= 1'b1;
      mdo_oe_reg <= 1'b0;
      bit_cnt_reg <= 7'h00;
      shift_reg <= 64'h0;
      capture_reg <= 16'h0000;
    end
    else if (start)
    begin
      mdo_reg <= frame[63];
      mdo_oe_reg <= 1'b1;
      shift_reg <= {frame[62:0], 1'b1};
      bit_cnt_reg <= 7'h01;
    end
    else if (tick)
    begin
      mdc_reg <= !mdc_reg;
      if (!mdc_reg)
        capture_reg <= {capture_reg[14:0], mgmt_data_in};
      else if (bit_cnt_reg == FRAME_BITS)
        mdo_oe_reg <= 1'b0;
      else
      begin
        mdo_reg <= shift_reg[63];
        shift_reg <= {shift_reg[62:0], 1'b1};
        bit_cnt_reg <= bit_cnt_reg + 7'h01;
        mdo_oe_reg <= !(cmd_reg == CMD_READ &&
                        bit_cnt_reg >= READ_RELEASE_BIT);
      end
    end
  end

  // Read result lands as the read frame ends.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      rdata_reg <= 16'h0000;
    else if (tick && mdc_reg && bit_cnt_reg == FRAME_BITS &&
             cmd_reg == CMD_READ)
      rdata_reg <= capture_reg;
  end

  assign bus_rdata = bus_rdata_reg;
  assign mgmt_clock = mdc_reg;
  assign mgmt_data_out = mdo_reg;
  assign mgmt_data_oe = mdo_oe_reg;
  assign phy_mode = mode_reg;
  assign phy_power_down_bit = phy_power_down_bit_reg;
  assign phy_hw_reset = rst_reg;
  assign system_clock_slow = slow_reg;
  assign wake_on_lan_enable = wol_reg;

  // ***************************************************
  // Assertions
  // ***************************************************
  AST_MRU_CLAMP: assert property (@(posedge clock) disable iff (reset)
    bus_wr && (bus_addr == ADDR_MRU_HI || bus_addr == ADDR_MRU_LO)
    |=> mru_reg <= MRU_LIMIT)
    else $error("Receive unit exceeds the limit after a write.");
  AST_MODE_MIRROR: assert property (@(posedge clock) disable iff (reset)
    ##1 link_status_reg[5:3] == $past(mode_reg))
    else $error("Link status does not mirror the mode.");
  AST_LINK_LIVE: assert property (@(posedge clock) disable iff (reset)
    ##1 link_status_reg[0] == $past(link_up_flag) &&
    link_status_reg[7] == $past(cable_unplugged_flag))
    else $error("Link status does not follow the PHY.");
  AST_ACT_STATUS: assert property (@(posedge clock) disable iff (reset)
    ##1 act_status_reg[7] == $past(phy_active_flag) &&
    act_status_reg[6:3] == 4'h0)
    else $error("Activity status is wrong.");
  AST_START_CMD: assert property (@(posedge clock) disable iff (reset)
    start |=> state_reg == PHYMC_XFER && cmd_reg != CMD_NONE ##1
    (cmd_reg != CMD_NONE)[*3])
    else $error("Access did not start or cleared too early.");
  AST_MDC_32: assert property (@(posedge clock) disable iff (reset)
    $rose(mdc_reg) && half_reg == HALF_32 |->
    mdc_reg[*8] ##8 mdc_reg ##1 !mdc_reg)
    else $error("Management clock high time wrong for divide by 32.");
  AST_SLOW_CLK: assert property (@(posedge clock) disable iff (reset)
    phy_power_down_bit_reg |=> system_clock_slow)
    else $error("Power-down did not select the slow clock.");
  AST_WOL: assert property (@(posedge clock) disable iff (reset)
    ##1 wake_on_lan_enable == ($past(wake_reg) && $past(global_mode_wake)))
    else $error("Wake enable does not need both bits.");
  AST_RST_CLEAR: assert property (@(posedge clock) disable iff (reset)
    rst_reg && rst_seen_idle_reg && phy_active_flag && !wr_ctrl_ok
    |=> !rst_reg ##1 !system_clock_slow || $past(phy_power_down_bit_reg) ||
    $past(system_clock_select))
    else $error("PHY reset bit did not clear on activity.");
  AST_LOCKED: assert property (@(posedge clock) disable iff (reset)
    bus_wr && !phy_write_lock |=> $stable(mode_reg) && $stable(phy_power_down_bit_reg))
    else $error("Control register changed while locked.");

endmodule : phymc_top

// file: hw/phymc_pkg.sv
// Constants, register map and types of the PHY management control block.
package phymc_pkg;

  // ***************************************************
  // Register offsets on the host interface
  // ***************************************************
  localparam logic [15:0] ADDR_MRU_HI = 16'h003A;
  localparam logic [15:0] ADDR_MRU_LO = 16'h003B;
  localparam logic [15:0] ADDR_LINK_STATUS = 16'h003C;
  localparam logic [15:0] ADDR_ACT_STATUS = 16'h003D;
  localparam logic [15:0] ADDR_IND_ADDRESS = 16'h003F;
  localparam logic [15:0] ADDR_WDATA_LO = 16'h0040;
  localparam logic [15:0] ADDR_WDATA_HI = 16'h0041;
  localparam logic [15:0] ADDR_RDATA_LO = 16'h0042;
  localparam logic [15:0] ADDR_RDATA_HI = 16'h0043;
  localparam logic [15:0] ADDR_ACCESS_CMD = 16'h0044;
  localparam logic [15:0] ADDR_CLK_DIVIDER = 16'h0045;
  localparam logic [15:0] ADDR_MODE_CTRL = 16'h0046;
  localparam logic [15:0] ADDR_POWER_CTRL = 16'h0047;

  // ***************************************************
  // Reset values, limits and field positions
  // ***************************************************
  localparam logic [15:0] MRU_RESET = 16'hFFFF;
  localparam logic [15:0] MRU_LIMIT = 16'h05C0;
  localparam logic [7:0] LINK_RESET = 8'h00;
  localparam logic [7:0] ACT_RESET = 8'h81;
  localparam logic [7:0] DIVIDER_RESET = 8'h01;
  localparam logic [7:0] POWER_RSVD_ONES = 8'h40;
  localparam int CR1_WAKE_BIT = 7;
  localparam int CR1_PHY_POWER_DOWN_BIT_BIT = 5;
  localparam int CR1_RESET_BIT = 0;
  localparam logic [4:0] ADDR_FIELD_MASK = 5'h1F;

  // ***************************************************
  // Access codes, divider settings and frame layout
  // ***************************************************
  localparam logic [7:0] CMD_NONE = 8'h00;
  localparam logic [7:0] CMD_WRITE = 8'h01;
  localparam logic [7:0] CMD_READ = 8'h02;
  localparam logic [7:0] DIV_SEL_32 = 8'h00;
  localparam logic [7:0] DIV_SEL_64 = 8'h01;
  localparam logic [6:0] HALF_32 = 7'h10;
  localparam logic [6:0] HALF_64 = 7'h20;
  localparam logic [6:0] HALF_128 = 7'h40;
  localparam logic [6:0] FRAME_BITS = 7'h40;
  localparam logic [6:0] READ_RELEASE_BIT = 7'h2E;
  localparam logic [31:0] FRAME_PREAMBLE = 32'hFFFFFFFF;
  localparam logic [1:0] FRAME_START = 2'h1;
  localparam logic [1:0] FRAME_OP_WRITE = 2'h1;
  localparam logic [1:0] FRAME_OP_READ = 2'h2;
  localparam logic [1:0] FRAME_TURN_WRITE = 2'h2;
  localparam logic [1:0] FRAME_TURN_READ = 2'h3;

  typedef enum logic [0:0]
  {
    PHYMC_IDLE = 1'b0,
    PHYMC_XFER = 1'b1
  } phymc_state_t;

endpackage : phymc_pkg

// file: tb/phymc_phy_model.sv
// Behavioural PHY that answers management frames on the serial port.
`timescale 1ns/100ps
module phymc_phy_model
#(
  parameter logic [4:0] PHY_ADDR = 5'h00
)
(
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Management serial port.
  input wire logic mgmt_clock,
  input wire logic mgmt_data_out,
  input wire logic mgmt_data_oe,
  output logic mgmt_data_in
);
  logic [15:0] mem [32];
  logic [63:0] shift_reg;
  logic [4:0] reg_sel;
  logic mdc_reg;
  logic is_read;
  logic drv_oe;
  logic drv_bit;
  int bits;
  int cyc;
  int period;
  int frames;
  int frame_bad;

  // The data line has a pull-up, so a released line reads one.
  assign mgmt_data_in = mgmt_data_oe ? mgmt_data_out :
                        (drv_oe ? drv_bit : 1'b1);

  // Bits are taken on the rising management edge and the answer is put
  // out on the falling one, half a period before the block samples it.
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      mdc_reg <= 1'b0;
      drv_oe <= 1'b0;
      drv_bit <= 1'b1;
      is_read = 1'b0;
      bits = 0;
      cyc = 0;
      frames = 0;
      frame_bad = 0;
      for (int i = 0; i < 32; i++)
        mem[i] = 16'h9000 + 16'(i * 16'h0111);
    end
    else
    begin
      mdc_reg <= mgmt_clock;
      cyc = cyc + 1;
      if (mgmt_clock && !mdc_reg)
      begin
        if (bits > 0)
          period = cyc;
        cyc = 0;
        shift_reg = {shift_reg[62:0], mgmt_data_in};
        bits = bits + 1;
        if (bits == 46)
        begin
          is_read = (shift_reg[11:10] == 2'b10);
          reg_sel = shift_reg[4:0];
        end
        if (bits == 64)
        begin
          frames = frames + 1;
          if (shift_reg[63:30] != {32'hFFFFFFFF, 2'b01} ||
              shift_reg[29:28] == 2'b00 || shift_reg[29:28] == 2'b11 ||
              shift_reg[27:23] != PHY_ADDR || shift_reg[17:16] != 2'b10)
            frame_bad = frame_bad + 1;
          if (!is_read)
            mem[reg_sel] = shift_reg[15:0];
          bits = 0;
        end
      end
      else if (!mgmt_clock && mdc_reg)
      begin
        if (is_read && bits == 47)
        begin
          drv_oe <= 1'b1;
          drv_bit <= 1'b0;
        end
        else if (is_read && bits >= 48)
          drv_bit <= mem[reg_sel][63 - bits];
        else
          drv_oe <= 1'b0;
      end
    end
  end
endmodule : phymc_phy_model

// file: tb/testbench.sv
// Self-checking bench for the PHY management control block.
`timescale 1ns/100ps
module testbench;
  import phymc_pkg::*;
  logic clock, reset, bus_wr, bus_rd;
  logic [15:0] bus_addr;
  logic [7:0] bus_wdata, bus_rdata;
  logic phy_write_lock, system_clock_select, global_mode_wake;
  logic cable_unplugged_flag, actual_duplex_flag, actual_speed_flag;
  logic link_up_flag, phy_active_flag, new_page_received_flag;
  logic low_power_idle_flag, calibration_flag;
  logic mgmt_clock, mgmt_data_out, mgmt_data_oe, mgmt_data_in;
  logic [2:0] phy_mode;
  logic phy_power_down_bit, phy_hw_reset, system_clock_slow;
  logic wake_on_lan_enable;
  int fails = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [15:0] ra [14] = '{ADDR_MRU_HI, ADDR_MRU_LO, ADDR_LINK_STATUS,
    ADDR_ACT_STATUS, ADDR_IND_ADDRESS, ADDR_WDATA_LO, ADDR_WDATA_HI,
    ADDR_RDATA_LO, ADDR_RDATA_HI, ADDR_ACCESS_CMD, ADDR_CLK_DIVIDER,
    ADDR_POWER_CTRL, ADDR_MODE_CTRL, 16'h003E};
  logic [7:0] rv [14] = '{8'hFF, 8'hFF, 8'h00, 8'h81, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h01, 8'h41, 8'h00, 8'h00};
  logic [15:0] wdat;
  logic [4:0] rsel;

  phymc_top u_phymc_top (.clock(clock), .reset(reset), .bus_addr(bus_addr),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .phy_write_lock(phy_write_lock),
    .system_clock_select(system_clock_select),
    .global_mode_wake(global_mode_wake),
    .cable_unplugged_flag(cable_unplugged_flag),
    .actual_duplex_flag(actual_duplex_flag),
    .actual_speed_flag(actual_speed_flag), .link_up_flag(link_up_flag),
    .phy_active_flag(phy_active_flag),
    .new_page_received_flag(new_page_received_flag),
    .low_power_idle_flag(low_power_idle_flag),
    .calibration_flag(calibration_flag), .mgmt_clock(mgmt_clock),
    .mgmt_data_out(mgmt_data_out), .mgmt_data_oe(mgmt_data_oe),
    .mgmt_data_in(mgmt_data_in), .phy_mode(phy_mode),
    .phy_power_down_bit(phy_power_down_bit), .phy_hw_reset(phy_hw_reset),
    .system_clock_slow(system_clock_slow),
    .wake_on_lan_enable(wake_on_lan_enable));

  phymc_phy_model u_phymc_phy_model (.clock(clock), .reset(reset),
    .mgmt_clock(mgmt_clock), .mgmt_data_out(mgmt_data_out),
    .mgmt_data_oe(mgmt_data_oe), .mgmt_data_in(mgmt_data_in));

  // *********************************************
  // Clock, hang guard and access tasks
  // *********************************************
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Three dividers times two frames fit well inside this ceiling.
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 80000)
    begin
      fails = fails + 1;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (fails == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Inputs move 1 ns after the edge, so the block never sees a race.
  // An idle edge follows each strobe, so back-to-back calls never lower
  // and raise the same strobe in one time step.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(posedge clock);
    #1;
    bus_wr = 1'b0;
    @(posedge clock);
    #1;
  endtask : wr

  task automatic rd(input logic [15:0] a);
    bus_addr = a;
    bus_rd = 1'b1;
    @(posedge clock);
    #1;
    bus_rd = 1'b0;
    @(posedge clock);
    #1;
  endtask : rd

  task automatic rchk(input logic [15:0] a, input logic [7:0] e);
    rd(a);
    check(16'(bus_rdata), 16'(e));
  endtask : rchk

  task automatic step2();
    repeat (2) @(posedge clock);
    #1;
  endtask : step2

  // Polls the access field, bounded so a stuck engine cannot hang us.
  task automatic wait_idle();
    int k;
    k = 0;
    rd(ADDR_ACCESS_CMD);
    while (bus_rdata !== 8'h00 && k < 10000)
    begin
      rd(ADDR_ACCESS_CMD);
      k = k + 1;
    end
    check(16'(bus_rdata), 16'h0000);
  endtask : wait_idle

  task automatic pulse_activity();
    phy_active_flag = 1'b0;
    step2();
    phy_active_flag = 1'b1;
    repeat (3) step2();
  endtask : pulse_activity

  // *********************************************
  // Main sequence
  // *********************************************
  initial
  begin
    {bus_wr, bus_rd, bus_addr, bus_wdata} = '0;
    {phy_write_lock, system_clock_select, global_mode_wake} = 3'h0;
    {cable_unplugged_flag, actual_duplex_flag, actual_speed_flag} = 3'h0;
    {link_up_flag, new_page_received_flag, low_power_idle_flag} = 3'h0;
    {phy_active_flag, calibration_flag} = 2'h3;
    reset = 1'b1;
    repeat (5) @(posedge clock);
    #1;
    reset = 1'b0;
    for (int i = 0; i < 14; i++)
      rchk(ra[i], rv[i]);
    check(16'(phy_hw_reset), 16'h0001);
    // Receive unit clamps after each byte, with the other byte held.
    wr(ADDR_MRU_HI, 8'h05);
    rchk(ADDR_MRU_LO, 8'hC0);
    wr(ADDR_MRU_LO, 8'hC1);
    rchk(ADDR_MRU_LO, 8'hC0);
    wr(ADDR_MRU_HI, 8'h03);
    wr(ADDR_MRU_LO, 8'hE8);
    rchk(ADDR_MRU_HI, 8'h03);
    rchk(ADDR_MRU_LO, 8'hE8);
    // Control writes while locked must be dropped.
    wr(ADDR_MODE_CTRL, 8'h07);
    wr(ADDR_POWER_CTRL, 8'h20);
    step2();
    check(16'({phy_mode, phy_power_down_bit}), 16'h0000);
    phy_write_lock = 1'b1;
    for (int m = 0; m < 8; m++)
    begin
      {cable_unplugged_flag, actual_duplex_flag, actual_speed_flag,
        link_up_flag} = 4'(m * 5 + 3);
      wr(ADDR_MODE_CTRL, 8'(m));
      step2();
      check(16'(phy_mode), 16'(m));
      rchk(ADDR_LINK_STATUS, {cable_unplugged_flag, 1'b0, 3'(m),
        actual_duplex_flag, actual_speed_flag, link_up_flag});
    end
    pulse_activity();
    check(16'({phy_hw_reset, system_clock_slow}), 16'h0000);
    wr(ADDR_POWER_CTRL, 8'h20);
    step2();
    check(16'({phy_power_down_bit, system_clock_slow}), 16'h0003);
    rchk(ADDR_POWER_CTRL, 8'h60);
    wr(ADDR_POWER_CTRL, 8'h00);
    system_clock_select = 1'b1;
    step2();
    check(16'({phy_power_down_bit, system_clock_slow}), 16'h0001);
    system_clock_select = 1'b0;
    wr(ADDR_POWER_CTRL, 8'h01);
    step2();
    check(16'({phy_hw_reset, system_clock_slow}), 16'h0003);
    pulse_activity();
    check(16'({phy_hw_reset, system_clock_slow}), 16'h0000);
    wr(ADDR_POWER_CTRL, 8'h80);
    step2();
    check(16'(wake_on_lan_enable), 16'h0000);
    global_mode_wake = 1'b1;
    step2();
    check(16'(wake_on_lan_enable), 16'h0001);
    rchk(ADDR_POWER_CTRL, 8'h40);
    for (int k = 0; k < 16; k++)
    begin
      {phy_active_flag, new_page_received_flag, low_power_idle_flag,
        calibration_flag} = 4'(k ^ 8);
      step2();
      rchk(ADDR_ACT_STATUS, {phy_active_flag, 4'h0, new_page_received_flag,
        low_power_idle_flag, calibration_flag});
    end
    wr(ADDR_ACCESS_CMD, 8'h03);
    rchk(ADDR_ACCESS_CMD, 8'h00);
    // Indirect write then read, once per divider setting.
    for (int d = 0; d < 3; d++)
    begin
      int f0;
      rsel = 5'(d * 7 + 3);
      wdat = 16'hA5C3 ^ 16'(d * 16'h1111);
      system_clock_select = (d == 0);
      wr(ADDR_CLK_DIVIDER, 8'(d));
      rchk(ADDR_CLK_DIVIDER, 8'(d));
      wr(ADDR_IND_ADDRESS, {3'h7, rsel});
      rchk(ADDR_IND_ADDRESS, {3'h0, rsel});
      wr(ADDR_WDATA_LO, wdat[7:0]);
      wr(ADDR_WDATA_HI, wdat[15:8]);
      rchk(ADDR_WDATA_HI, wdat[15:8]);
      f0 = u_phymc_phy_model.frames;
      wr(ADDR_ACCESS_CMD, CMD_WRITE);
      rchk(ADDR_ACCESS_CMD, CMD_WRITE);
      wr(ADDR_ACCESS_CMD, CMD_READ);
      wait_idle();
      check(16'(u_phymc_phy_model.frames - f0), 16'h0001);
      check(u_phymc_phy_model.mem[rsel], wdat);
      check(16'(u_phymc_phy_model.period), 16'(32 << d));
      wr(ADDR_IND_ADDRESS, {3'h0, rsel ^ 5'h10});
      wr(ADDR_ACCESS_CMD, CMD_READ);
      wait_idle();
      wdat = u_phymc_phy_model.mem[rsel ^ 5'h10];
      rchk(ADDR_RDATA_LO, wdat[7:0]);
      rchk(ADDR_RDATA_HI, wdat[15:8]);
    end
    check(16'(u_phymc_phy_model.frame_bad), 16'h0000);
    print_verdict();
  end
endmodule : testbench
